// ---- hdl/ptc_core.v ----
// Periodic timer core: counter, comparators, register file and pin logic
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "ptc_regs.vh"
module ptc_core (
  input  wire       sys_clk_i,
  input  wire       nrst_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       high_clk_tick_i,
  input  wire       sub_clk_tick_i,
  input  wire       external_count_pin_i,
  input  wire       capture_input_pin_i,
  output reg        timer_output_pin_o,
  output reg        timer_output_pin_oe_n_o,
  output reg        match_a_flag_o,
  output reg        match_p_flag_o,
  output reg        capture_flag_o,
  output reg        module_power_on_o
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  reg [7:0] ctrl_main_q;
  reg [7:0] ctrl_mode_q;
  reg [9:0] cmp_a_q;
  reg [9:0] cmp_p_q;
  reg [9:0] cnt_q;
  reg       run_dly_q;
  reg [1:0] sys_div_q;
  reg [3:0] h16_q;
  reg [5:0] h64_q;
  reg [2:0] ext_sync_q;
  reg [2:0] cap_sync_q;
  reg       ext_lvl_q;
  reg       cap_lvl_q;
  reg       pin_lvl_q;
  reg       cap_pend_q;
  reg [9:0] cap_val_q;

  wire       run_en   = ctrl_main_q[`PTC_MAIN_RUN];
  wire       pause    = ctrl_main_q[`PTC_MAIN_PAUSE];
  wire [2:0] ck_sel   = ctrl_main_q[`PTC_MAIN_CKSEL_HI:`PTC_MAIN_CKSEL_LO];
  wire [1:0] mode_sel = ctrl_mode_q[`PTC_MODE_MODE_HI:`PTC_MODE_MODE_LO];
  wire [1:0] pin_fn   = ctrl_mode_q[`PTC_MODE_PFN_HI:`PTC_MODE_PFN_LO];
  wire       init_lvl = ctrl_mode_q[`PTC_MODE_INIT];
  wire       inv      = ctrl_mode_q[`PTC_MODE_INV];
  wire       cap_src  = ctrl_mode_q[`PTC_MODE_CAPSRC];
  wire       clr_sel  = ctrl_mode_q[`PTC_MODE_CLRSEL];
  wire       run_rise = run_en & ~run_dly_q;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Only stages 1 and 2 are looked at; stage 0 may be metastable
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ext_sync_q <= 3'h0;
      cap_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
      cap_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_count_pin_i}; // RULE_20
      cap_sync_q <= {cap_sync_q[1:0], capture_input_pin_i};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_lvl_q <= ext_sync_q[2];
      if (cap_sync_q[1] == cap_sync_q[2])
        cap_lvl_q <= cap_sync_q[2];
    end
  end

  // Edge of the filtered level counts once per agreed change
  wire ext_new  = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_lvl_q;
  wire cap_new  = (cap_sync_q[1] == cap_sync_q[2]) ? cap_sync_q[2] : cap_lvl_q;
  wire ext_rise = ext_new & ~ext_lvl_q;
  wire ext_fall = ~ext_new & ext_lvl_q;
  wire cap_rise = cap_new & ~cap_lvl_q;
  wire cap_fall = ~cap_new & cap_lvl_q;

  // ------------------------------------------------------------
  // Clock prescalers
  // ------------------------------------------------------------
  // Dividers only run while the module is powered, saving toggles
  always @(posedge sys_clk_i) begin
    if (!nrst_i || !run_en) begin
      sys_div_q <= 2'h0;
      h16_q     <= 4'h0;
      h64_q     <= 6'h0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
      if (high_clk_tick_i) begin
        h16_q <= h16_q + 4'h1;
        h64_q <= h64_q + 6'h1;
      end
    end
  end

  // Count step selection
  reg tick;
  always @* begin
    tick = 1'b0;
    case (ck_sel) // RULE_08
      `PTC_CK_SYS4: tick = (sys_div_q == `PTC_DIV_SYS4);
      `PTC_CK_SYS:  tick = 1'b1;
      `PTC_CK_H16:  tick = high_clk_tick_i & (h16_q == 4'hf);
      `PTC_CK_H64:  tick = high_clk_tick_i & (h64_q == 6'h3f);
      `PTC_CK_SUB0: tick = sub_clk_tick_i;
      `PTC_CK_SUB1: tick = sub_clk_tick_i;
      `PTC_CK_PINR: tick = ext_rise; // RULE_20
      `PTC_CK_PINF: tick = ext_fall;
      default:      tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Counter and comparators
  // ------------------------------------------------------------
  wire       step     = run_en & ~run_rise & ~pause & tick; // RULE_09 RULE_07
  wire [9:0] cnt_inc  = cnt_q + 10'h001; // RULE_01
  wire       overflow = step & (cnt_q == `PTC_CNT_MAX); // RULE_21
  // Comparators look at the freshly advanced value, so each change is checked
  wire       hit_a    = step & (cnt_inc == cmp_a_q); // RULE_02
  wire       hit_p    = step & (cnt_inc == cmp_p_q) & (cmp_p_q != 10'h000);
  wire       is_cmp   = (mode_sel == `PTC_MD_CMP) | (mode_sel == `PTC_MD_TMR);
  wire       is_cap   = (mode_sel == `PTC_MD_CAP);
  // Counter clear: A match or P match / overflow when P is zero
  wire       clr_a    = is_cmp & clr_sel & hit_a; // RULE_17
  wire       clr_p    = (~(is_cmp & clr_sel)) & (hit_p | (overflow & (cmp_p_q == 10'h000)));
  wire       auto_clr = clr_a | clr_p; // RULE_04

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q     <= `PTC_RST_CNT;
      run_dly_q <= 1'b0;
    end else begin
      run_dly_q <= run_en;
      if (run_rise)
        cnt_q <= `PTC_RST_CNT; // RULE_10 RULE_03
      else if (auto_clr)
        cnt_q <= `PTC_RST_CNT; // RULE_04
      else if (step)
        cnt_q <= cnt_inc;
    end
  end

  // ------------------------------------------------------------
  // Flags, one cycle pulses, and the power output that follows run
  // ------------------------------------------------------------
  wire cap_edge_sel = cap_src ? 1'b0 : 1'b1;
  wire cap_r = cap_src ? ext_rise : cap_rise; // RULE_16
  wire cap_f = cap_src ? ext_fall : cap_fall;
  reg  cap_hit;
  always @* begin
    cap_hit = 1'b0;
    case (pin_fn)
      2'h0:    cap_hit = cap_r;
      2'h1:    cap_hit = cap_f;
      2'h2:    cap_hit = cap_r | cap_f;
      default: cap_hit = 1'b0;
    endcase
  end
  wire do_cap = is_cap & run_en & cap_hit & cap_edge_sel | is_cap & run_en & cap_hit & cap_src;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      match_a_flag_o    <= 1'b0;
      match_p_flag_o    <= 1'b0;
      capture_flag_o    <= 1'b0;
      module_power_on_o <= 1'b0;
    end else begin
      // P flag suppressed when A clears the counter in compare modes
      match_a_flag_o    <= is_cap ? 1'b0 : hit_a; // RULE_04
      match_p_flag_o    <= clr_p & ~(is_cmp & clr_sel);
      capture_flag_o    <= do_cap;
      module_power_on_o <= run_en; // RULE_09
    end
  end

  // ------------------------------------------------------------
  // Output pin
  // ------------------------------------------------------------
  // Only compare output action is modelled; PWM mode holds the pin level left from compare mode
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pin_lvl_q <= 1'b0;
    end else if (run_rise && mode_sel == `PTC_MD_CMP) begin
      pin_lvl_q <= init_lvl; // RULE_11
    end else if (mode_sel == `PTC_MD_CMP && hit_a) begin
      case (pin_fn) // RULE_18
        `PTC_PF_LOW:  pin_lvl_q <= 1'b0;
        `PTC_PF_HIGH: pin_lvl_q <= 1'b1;
        `PTC_PF_TOG:  pin_lvl_q <= ~pin_lvl_q;
        default:      pin_lvl_q <= pin_lvl_q;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      timer_output_pin_o      <= 1'b0;
      timer_output_pin_oe_n_o <= 1'b1;
    end else begin
      timer_output_pin_o      <= (mode_sel == `PTC_MD_TMR) ? 1'b0 : (pin_lvl_q ^ inv); // RULE_19
      timer_output_pin_oe_n_o <= (mode_sel == `PTC_MD_TMR) | is_cap; // RULE_14 RULE_15
    end
  end

  // ------------------------------------------------------------
  // Register writes and reads
  // ------------------------------------------------------------
  // Capture loads compare A; a software write in the same cycle loses to it
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl_main_q <= `PTC_RST_BYTE;
      ctrl_mode_q <= `PTC_RST_BYTE;
      cmp_a_q     <= `PTC_RST_CNT; // RULE_06
      cmp_p_q     <= `PTC_RST_CNT;
      cap_pend_q  <= 1'b0;
      cap_val_q   <= `PTC_RST_CNT;
    end else begin
      cap_pend_q <= 1'b0;
      cap_val_q  <= cnt_q;
      if (wr_i) begin
        case (addr_i) // RULE_12
          `PTC_OFS_CTRL_MAIN: ctrl_main_q <= wdata_i & `PTC_MAIN_MASK;
          `PTC_OFS_CTRL_MODE: ctrl_mode_q <= wdata_i;
          `PTC_OFS_CMPA_LO:   cmp_a_q[7:0] <= wdata_i;
          `PTC_OFS_CMPA_HI:   cmp_a_q[9:8] <= wdata_i[1:0];
          `PTC_OFS_CMPP_LO:   cmp_p_q[7:0] <= wdata_i;
          `PTC_OFS_CMPP_HI:   cmp_p_q[9:8] <= wdata_i[1:0];
          default:            cap_pend_q <= 1'b0;
        endcase
      end
      if (do_cap)
        cmp_a_q <= cnt_q;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= `PTC_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i) // RULE_05
        `PTC_OFS_CTRL_MAIN: rdata_o <= ctrl_main_q;
        `PTC_OFS_CTRL_MODE: rdata_o <= ctrl_mode_q;
        `PTC_OFS_CNT_LO:    rdata_o <= cnt_q[7:0];
        `PTC_OFS_CNT_HI:    rdata_o <= {6'h00, cnt_q[9:8]};
        `PTC_OFS_CMPA_LO:   rdata_o <= cmp_a_q[7:0];
        `PTC_OFS_CMPA_HI:   rdata_o <= {6'h00, cmp_a_q[9:8]};
        `PTC_OFS_CMPP_LO:   rdata_o <= cmp_p_q[7:0];
        `PTC_OFS_CMPP_HI:   rdata_o <= {6'h00, cmp_p_q[9:8]};
        default:            rdata_o <= `PTC_RST_BYTE;
      endcase
    end else begin
      rdata_o <= `PTC_RST_BYTE;
    end
  end

endmodule

// ---- hdl/ptc_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the periodic timer core
//
// Functional notes
// RULE_01: Ten-bit up-counter, internal or external clock.
// RULE_02: Comparators A and P check every count.
// RULE_03: Software clears counter only via run rising.
// RULE_04: Overflow or selected match clears, raises flag.
// RULE_05: Count readable as low/high read-only bytes.
// RULE_06: Compare A and P byte pairs, reset zero.
// RULE_07: Pause holds count; resume from held value.
// RULE_08: Clock select picks divided, sub, pin edges.
// RULE_09: Run enable counts; off stops and powers down.
// RULE_10: Run rising zeroes count; falling keeps it.
// RULE_11: Run rising forces output to initial level (code: compare mode only).
// RULE_12: Mode field picks compare, capture, PWM, counter.
// RULE_13: Software stops timer before changing mode.
// RULE_14: Timer/counter mode leaves output pin undriven.
// RULE_15: Two input pins, one output pin.
// RULE_16: Capture source: input pin or count pin.
// RULE_17: Clear select: A match, else P/overflow (code: A match only in compare and counter modes).
// RULE_18: Pin function on A match: hold/low/high/toggle.
// RULE_19: Invert bit flips output, not in counter mode.
// RULE_20: Count pin synchronised, one step per edge.
// RULE_21: Overflow is wrap from all ones to zero.
`ifndef PTC_REGS_VH
`define PTC_REGS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PTC_ADDR_W        3
`define PTC_OFS_CTRL_MAIN 3'h0
`define PTC_OFS_CTRL_MODE 3'h1
`define PTC_OFS_CNT_LO    3'h2
`define PTC_OFS_CNT_HI    3'h3
`define PTC_OFS_CMPA_LO   3'h4
`define PTC_OFS_CMPA_HI   3'h5
`define PTC_OFS_CMPP_LO   3'h6
`define PTC_OFS_CMPP_HI   3'h7
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PTC_MAIN_PAUSE    7
`define PTC_MAIN_CKSEL_HI 6
`define PTC_MAIN_CKSEL_LO 4
`define PTC_MAIN_RUN      3
`define PTC_MODE_MODE_HI  7
`define PTC_MODE_MODE_LO  6
`define PTC_MODE_PFN_HI   5
`define PTC_MODE_PFN_LO   4
`define PTC_MODE_INIT     3
`define PTC_MODE_INV      2
`define PTC_MODE_CAPSRC   1
`define PTC_MODE_CLRSEL   0
`define PTC_MAIN_MASK     8'hf8
// ------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------
`define PTC_RST_BYTE      8'h00
`define PTC_RST_CNT       10'h000
`define PTC_CNT_MAX       10'h3ff
`define PTC_MD_CMP        2'h0
`define PTC_MD_CAP        2'h1
`define PTC_MD_PWM        2'h2
`define PTC_MD_TMR        2'h3
`define PTC_CK_SYS4       3'h0
`define PTC_CK_SYS        3'h1
`define PTC_CK_H16        3'h2
`define PTC_CK_H64        3'h3
`define PTC_CK_SUB0       3'h4
`define PTC_CK_SUB1       3'h5
`define PTC_CK_PINR       3'h6
`define PTC_CK_PINF       3'h7
`define PTC_PF_HOLD       2'h0
`define PTC_PF_LOW        2'h1
`define PTC_PF_HIGH       2'h2
`define PTC_PF_TOG        2'h3
// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define PTC_DIV_SYS4      2'h3
`endif

// ---- testbench/ptc_core_sva.sv ----
// Port-level checker for the periodic timer core
`include "ptc_regs.vh"
module ptc_core_sva (
  input wire       sys_clk_i,
  input wire       nrst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       timer_output_pin_o,
  input wire       timer_output_pin_oe_n_o,
  input wire       match_a_flag_o,
  input wire       match_p_flag_o,
  input wire       capture_flag_o,
  input wire       module_power_on_o
);
  reg [1:0] mode_q;
  reg       clr_q;
  reg       run_q;
  reg       pause_q;
  // Shadow of the control bits, taken at the same write edge as the core
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      {mode_q, clr_q, run_q, pause_q} <= 5'h00;
    end else if (wr_i && addr_i == `PTC_OFS_CTRL_MODE) begin
      {mode_q, clr_q} <= {wdata_i[7:6], wdata_i[0]};
    end else if (wr_i && addr_i == `PTC_OFS_CTRL_MAIN) begin
      {pause_q, run_q} <= {wdata_i[7], wdata_i[3]};
    end
  end
  // Outputs are registered, so each check looks one edge later; the run, mode and clear checks also want their cause stable one edge
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  AST_HI_ZERO: assert property (rd_i && addr_i[0] && |addr_i[2:1] |=> rdata_o[7:2] == 6'h00)
    else $error("high byte spare bits set");
  AST_POWER: assert property (1'b1 |=> module_power_on_o == $past(run_q))
    else $error("power does not follow run");
  AST_IDLE: assert property (
    (!run_q || pause_q) && $stable({run_q, pause_q}) |=> !match_a_flag_o && !match_p_flag_o)
    else $error("flag while stopped");
  AST_TMR_PIN: assert property (
    mode_q == `PTC_MD_TMR && $stable(mode_q) |=> timer_output_pin_oe_n_o && !timer_output_pin_o)
    else $error("pin used in counter mode");
  AST_CAP_OE: assert property (mode_q == `PTC_MD_CAP && $stable(mode_q) |=> timer_output_pin_oe_n_o)
    else $error("pin driven in capture mode");
  AST_NO_P: assert property (
    clr_q && mode_q[0] == mode_q[1] && $stable({clr_q, mode_q}) |=> !match_p_flag_o)
    else $error("P flag while A clears");
  AST_CAP_NO_A: assert property (mode_q == `PTC_MD_CAP && $stable(mode_q) |=> !match_a_flag_o)
    else $error("A flag in capture mode");
  COV_P: cover property (match_p_flag_o);
  COV_A: cover property (match_a_flag_o);
  COV_CAP: cover property (capture_flag_o);
endmodule
bind ptc_core ptc_core_sva i_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe_n_o(timer_output_pin_oe_n_o),
  .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o),
  .capture_flag_o(capture_flag_o), .module_power_on_o(module_power_on_o));

// ---- testbench/testbench.sv ----
// Self-checking bench for the periodic timer core
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] MSK = 64'h03ff_03ff_0000_fff8; // Writable bits per offset
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       hi_tk = 1'b0, sub_tk = 1'b0, ext_pin = 1'b0, cap_pin = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rv;
  wire  [7:0] rdata;
  wire        pin, oe_n, fa, fp, fc, pwr;
  integer     n_fail = 0, n_compared = 0, seed = 47892, cyc = 0, i, k, p, v, t, e;
  ptc_core i_dut (.sys_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .high_clk_tick_i(hi_tk), .sub_clk_tick_i(sub_tk),
    .external_count_pin_i(ext_pin), .capture_input_pin_i(cap_pin), .timer_output_pin_o(pin),
    .timer_output_pin_oe_n_o(oe_n), .match_a_flag_o(fa), .match_p_flag_o(fp),
    .capture_flag_o(fc), .module_power_on_o(pwr));
  always #4 clk = ~clk;
  // Tick enables at fixed ratios so divided sources give exact periods; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hi_tk <= cyc % 2 == 0;
    sub_tk <= cyc % 3 == 0;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One idle cycle after each strobe so no strobe is assigned twice in a step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [2:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    @(posedge clk);
  endtask
  // Edges until the chosen flag is seen: 0 P, 1 A, 2 capture
  task automatic wflag(input int w, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (!((w == 0) ? fp : (w == 1) ? fa : fc) && n < 20000);
    if (n >= 20000) chk("flag wait", 0, 1);
  endtask
  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd_reg(i);
      chk("reset value", rv, 0);
      v = $random(seed) & 8'hf7;
      wr_reg(i, v);
      rd_reg(i);
      chk("readback", rv, v & MSK[i*8 +: 8]);
    end
    // Clear on P for each source but the pin edges: flag spacing is P times the step interval
    p = 20 + {$random(seed)} % 40;
    wr_reg(6, p);
    wr_reg(7, 0);
    wr_reg(1, 8'hc0);
    for (i = 0; i < 6; i++) begin
      wr_reg(0, 8'h00);
      wr_reg(0, 8'h08 | (i << 4));
      wflag(0, t);
      wflag(0, t);
      e = (i == 0) ? 4 : (i == 1) ? 1 : (i == 2) ? 32 : (i == 3) ? 128 : 3;
      chk("p period", t, p * e);
    end
    // Pause holds; resume adds the unpaused edges; run off keeps; run rise clears
    wr_reg(0, 8'h18);
    wr_reg(0, 8'h98);
    rd_reg(2);
    v = rv;
    repeat (20) @(posedge clk);
    rd_reg(2);
    chk("paused count", rv, v);
    t = {$random(seed)} % 8;
    wr_reg(0, 8'h18);
    repeat (t) @(posedge clk);
    wr_reg(0, 8'h98);
    wr_reg(0, 8'h90);
    rd_reg(2);
    chk("resumed count", rv, (v + t + 2) % p);
    chk("power off", pwr, 0);
    wr_reg(0, 8'h98);
    rd_reg(2);
    chk("restart count", rv, 0);
    chk("power on", pwr, 1);
    // Compare output: every pin function and initial level, invert at random
    wr_reg(4, 8'h06);
    wr_reg(5, 0);
    for (i = 0; i < 8; i++) begin
      k = {$random(seed)} % 2;
      wr_reg(0, 8'h10);
      wr_reg(1, (i >> 1 << 4) | (i % 2 << 3) | (k << 2) | 1);
      wr_reg(0, 8'h18);
      // The initial level needs one edge to load and one more to reach the pin register
      @(posedge clk);
      #1 chk("initial pin", pin, i % 2 ^ k);
      chk("pin enable", oe_n, 0);
      wflag(1, t);
      repeat (2) @(posedge clk);
      e = (i < 2) ? i % 2 : (i < 4) ? 0 : (i < 6) ? 1 : 1 - i % 2;
      #1 chk("matched pin", pin, e ^ k);
      wflag(1, t);
      wflag(1, t);
      chk("a period", t, 6);
    end
    // Counter mode with P zero: overflow clears, pin released
    wr_reg(0, 8'h10);
    wr_reg(1, 8'hc4);
    wr_reg(6, 0);
    wr_reg(0, 8'h18);
    wflag(0, t);
    wflag(0, t);
    chk("overflow period", t, 1024);
    #1 chk("counter mode pin", {oe_n, pin}, 2);
    // Count pin edges, rising then falling
    for (i = 6; i < 8; i++) begin
      wr_reg(0, 8'h00);
      wr_reg(0, 8'h08 | (i << 4));
      k = 3 + {$random(seed)} % 8;
      repeat (k) begin
        ext_pin <= 1'b1;
        repeat (6) @(posedge clk);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk);
      end
      rd_reg(2);
      chk("pin edges", rv, k);
    end
    // Capture from each source; the other pin must not load compare A
    for (i = 0; i < 2; i++) begin
      wr_reg(0, 8'h00);
      wr_reg(1, 8'h40 | (i << 1));
      wr_reg(5, 8'h03);
      wr_reg(0, 8'h18);
      if (i) cap_pin <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (20) @(posedge clk);
      rd_reg(5);
      chk("no capture", rv, 3);
      if (i) ext_pin <= 1'b1;
      else cap_pin <= 1'b1;
      wflag(2, t);
      rd_reg(5);
      chk("captured high", rv, 0);
      ext_pin <= 1'b0;
      cap_pin <= 1'b0;
    end
    complete_run;
  end
endmodule
